// File: shared/boc_defs.svh
// Purpose: constants for the buck output configuration register block
// Assumes: included by bare name from design files
// Notes: offsets, field positions, reset value and ramp scaling live here
// How it works
// - 8-bit rw register at 0x01, resets zero
// - bit 7 set forbids full duty
// - bit 6: 0 light-load, 1 forced pwm
// - bit 5: latch at first or fourth overheat
// - bit 4 enables discharge while powered down
// - bits 3:0 give 200 per code step
`ifndef BOC_DEFS_SVH
`define BOC_DEFS_SVH

// register address and power-on value
`define BOC_OUTCFG_ADDR     8'h01
`define BOC_OUTCFG_RESET    8'h00
// field positions inside the output configuration register
`define BOC_FULL_DUTY_BIT   7
`define BOC_FORCED_PWM_BIT  6
`define BOC_OT_POLICY_BIT   5
`define BOC_DISCHARGE_BIT   4
`define BOC_RAMP_MSB        3
`define BOC_RAMP_LSB        0
// ramp time per code step, microseconds per volt
`define BOC_RAMP_STEP_US    12'h0C8
// overheat events before latch-off in counted policy, minus one
`define BOC_OT_LAST_COUNT   3'h3
// unmapped read answer
`define BOC_READ_ZERO       8'h00

`endif

// File: shared/boc_pkg.sv
// Purpose: types shared by the buck output configuration block
// Assumes: nothing beyond the constants header
// Notes: switching mode and overheat state encodings
`default_nettype none
package boc_pkg;
    // switching mode seen by the power stage
    typedef enum logic [0:0] {
        BOC_MODE_LIGHT_LOAD = 1'b0,
        BOC_MODE_FORCED_PWM = 1'b1
    } boc_sw_mode_t;
    // overheat shutdown state
    typedef enum logic [0:0] {
        BOC_OT_RUN     = 1'b0,
        BOC_OT_LATCHED = 1'b1
    } boc_ot_state_t;
endpackage
`default_nettype wire

// File: src/boc_event_counter.sv
// Purpose: saturating counter of single-cycle event pulses
// Assumes: event and clear come from logic on clk
// Notes: clear wins over a same-cycle event; used for overheat counting
`timescale 1ns/1ps
`default_nettype none
module boc_event_counter #(
    parameter int WIDTH = 3
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             resetn,
    // control
    input  wire logic             clear,
    input  wire logic             event_pulse,
    // state
    output logic      [WIDTH-1:0] count_r
);
    // all-ones marks saturation so the count never wraps back to zero
    localparam logic [WIDTH-1:0] MAX_COUNT = {WIDTH{1'b1}};

    logic [WIDTH-1:0] count_nxt; // next count value

    // next count: clear, step, or hold
    always_comb begin
        count_nxt = count_r;
        if (clear) begin
            count_nxt = '0;
        end else if (event_pulse && count_r != MAX_COUNT) begin
            count_nxt = count_r + {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end

    // count register
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            count_r <= '0;
        end else begin
            count_r <= count_nxt;
        end
    end
endmodule // boc_event_counter
`default_nettype wire

// File: src/boc_top.sv
// Purpose: output configuration register of a step-down regulator
// Assumes: register port driven by a serial slave on clk; pins are async
// Notes: all outputs registered; one-cycle read latency
`timescale 1ns/1ps
`default_nettype none
`include "boc_defs.svh"
module boc_top (
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  resetn,
    // register port from the serial slave
    input  wire logic [7:0]            reg_addr,
    input  wire logic                  reg_wr,
    input  wire logic [7:0]            reg_wdata,
    output logic      [7:0]            reg_rdata_r,
    // asynchronous pins from the power stage
    input  wire logic                  overheat_pin,
    input  wire logic                  regulator_enable_pin,
    // controls toward the power stage
    output logic                       full_duty_inhibit_r,
    output logic                       forced_pulse_width_mode_r,
    output logic                       light_load_mode_r,
    output var boc_pkg::boc_sw_mode_t  sw_mode_r,
    output logic                       overheat_latched_r,
    output logic                       powerdown_discharge_r,
    output logic      [11:0]           step_ramp_time_r
);
    import boc_pkg::*;

    logic [7:0]      cfg_r;         // output configuration register
    logic            ot_meta_r;     // overheat sync stage one
    logic            ot_sync_r;     // overheat sync stage two
    logic            ot_prev_r;     // overheat previous level
    logic            en_meta_r;     // enable sync stage one
    logic            en_sync_r;     // enable sync stage two
    logic            ot_event;      // overheat rising edge
    logic [2:0]      ot_count_r;    // overheat events seen while running
    logic            ot_cnt_clear;  // restart overheat counting
    boc_ot_state_t   ot_state_r;    // overheat shutdown state
    boc_ot_state_t   ot_state_nxt;  // next overheat state
    logic            cfg_hit;       // register port addresses this register
    logic [11:0]     ramp_nxt;      // decoded ramp time

    assign cfg_hit = (reg_addr == `BOC_OUTCFG_ADDR);

    // register write; other addresses belong to neighbouring blocks
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cfg_r <= `BOC_OUTCFG_RESET;
        end else if (reg_wr && cfg_hit) begin
            cfg_r <= reg_wdata;
        end
    end

    // read data, zero when the address is not ours so a shared mux can OR
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            reg_rdata_r <= `BOC_READ_ZERO;
        end else if (cfg_hit) begin
            reg_rdata_r <= cfg_r;
        end else begin
            reg_rdata_r <= `BOC_READ_ZERO;
        end
    end

    // two-stage synchronisers for the pins
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ot_meta_r <= 1'b0;
            ot_sync_r <= 1'b0;
            en_meta_r <= 1'b0;
            en_sync_r <= 1'b0;
        end else begin
            ot_meta_r <= overheat_pin;
            ot_sync_r <= ot_meta_r;
            en_meta_r <= regulator_enable_pin;
            en_sync_r <= en_meta_r;
        end
    end

    // edge memory; reads only the settled stage
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ot_prev_r <= 1'b0;
        end else begin
            ot_prev_r <= ot_sync_r;
        end
    end

    // one overheat cycle is one rising edge of the warning level
    assign ot_event = ot_sync_r && !ot_prev_r;

    // counting restarts whenever the regulator is off or already latched
    assign ot_cnt_clear = !en_sync_r || (ot_state_r == BOC_OT_LATCHED);

    // overheat cycle counter
    boc_event_counter #(
        .WIDTH(3)
    ) u_ot_counter (
        .clk         (clk),
        .resetn      (resetn),
        .clear       (ot_cnt_clear),
        .event_pulse (ot_event),
        .count_r     (ot_count_r)
    );

    // overheat shutdown state; only a disable releases the latch
    always_comb begin
        ot_state_nxt = ot_state_r;
        unique case (ot_state_r)
            BOC_OT_RUN: begin
                if (en_sync_r && ot_event) begin
                    // policy 0 latches at once, policy 1 on the fourth cycle
                    if (!cfg_r[`BOC_OT_POLICY_BIT]) begin
                        ot_state_nxt = BOC_OT_LATCHED;
                    end else if (ot_count_r == `BOC_OT_LAST_COUNT) begin
                        ot_state_nxt = BOC_OT_LATCHED;
                    end
                end
            end
            BOC_OT_LATCHED: begin
                // a restart through the enable pin is the only way out
                if (!en_sync_r) begin
                    ot_state_nxt = BOC_OT_RUN;
                end
            end
        endcase
    end

    // overheat state register
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ot_state_r <= BOC_OT_RUN;
        end else begin
            ot_state_r <= ot_state_nxt;
        end
    end

    // latch flag mirrors the next state so it tracks the state register
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            overheat_latched_r <= 1'b0;
        end else begin
            overheat_latched_r <= (ot_state_nxt == BOC_OT_LATCHED);
        end
    end

    // duty and switching mode controls
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            full_duty_inhibit_r       <= 1'b0;
            forced_pulse_width_mode_r <= 1'b0;
            light_load_mode_r         <= 1'b1;
            sw_mode_r                 <= BOC_MODE_LIGHT_LOAD;
        end else begin
            full_duty_inhibit_r       <= cfg_r[`BOC_FULL_DUTY_BIT];
            forced_pulse_width_mode_r <= cfg_r[`BOC_FORCED_PWM_BIT];
            light_load_mode_r         <= !cfg_r[`BOC_FORCED_PWM_BIT];
            sw_mode_r                 <= cfg_r[`BOC_FORCED_PWM_BIT]
                                         ? BOC_MODE_FORCED_PWM
                                         : BOC_MODE_LIGHT_LOAD;
        end
    end

    // discharge only while powered down; never fights a running stage
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            powerdown_discharge_r <= 1'b0;
        end else begin
            powerdown_discharge_r <= cfg_r[`BOC_DISCHARGE_BIT]
                                     && (!en_sync_r
                                         || ot_state_r == BOC_OT_LATCHED);
        end
    end

    // ramp time: (code + 1) steps, so 0010 gives 600 and 1100 gives 2600
    always_comb begin
        ramp_nxt = 12'((12'({8'h00, cfg_r[`BOC_RAMP_MSB:`BOC_RAMP_LSB]})
                        + 12'h001) * `BOC_RAMP_STEP_US);
    end

    // ramp time register, 200 to 3200 fits twelve bits
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            step_ramp_time_r <= `BOC_RAMP_STEP_US;
        end else begin
            step_ramp_time_r <= ramp_nxt;
        end
    end

    // checks: write lands in the register one edge later
    write_store_a: assert property (
        @(posedge clk) disable iff (!resetn)
        (reg_wr && cfg_hit) |=> (cfg_r == $past(reg_wdata)))
        else $error("write to config register not stored");

    // checks: writes elsewhere leave the register alone
    foreign_write_a: assert property (
        @(posedge clk) disable iff (!resetn)
        (reg_wr && !cfg_hit) |=> $stable(cfg_r))
        else $error("foreign write changed config register");

    // checks: read returns register value one cycle on
    read_back_a: assert property (
        @(posedge clk) disable iff (!resetn)
        cfg_hit |=> (reg_rdata_r == $past(cfg_r)))
        else $error("read data does not match register");

    // checks: full duty inhibit follows bit 7 two edges after a write
    duty_inhibit_a: assert property (
        @(posedge clk) disable iff (!resetn)
        (reg_wr && cfg_hit) ##1 !(reg_wr && cfg_hit)
        |=> (full_duty_inhibit_r == $past(reg_wdata[`BOC_FULL_DUTY_BIT], 2)))
        else $error("full duty inhibit does not follow write");

    // checks: exactly one switching mode at a time, matching the enum
    mode_exclusive_a: assert property (
        @(posedge clk) disable iff (!resetn)
        (forced_pulse_width_mode_r != light_load_mode_r)
        && (forced_pulse_width_mode_r == (sw_mode_r == BOC_MODE_FORCED_PWM)))
        else $error("switching mode outputs disagree");

    // checks: immediate policy latches on the first cycle
    ot_first_a: assert property (
        @(posedge clk) disable iff (!resetn)
        (ot_state_r == BOC_OT_RUN && en_sync_r && ot_event
         && !cfg_r[`BOC_OT_POLICY_BIT]) |=> overheat_latched_r)
        else $error("immediate policy did not latch");

    // checks: counted policy holds off before the fourth cycle
    ot_counted_a: assert property (
        @(posedge clk) disable iff (!resetn)
        (ot_state_r == BOC_OT_RUN && cfg_r[`BOC_OT_POLICY_BIT]
         && ot_count_r < `BOC_OT_LAST_COUNT) |=> !overheat_latched_r)
        else $error("counted policy latched too early");

    // checks: discharge never runs while enabled and not latched
    discharge_gate_a: assert property (
        @(posedge clk) disable iff (!resetn)
        (en_sync_r && ot_state_r == BOC_OT_RUN) |=> !powerdown_discharge_r)
        else $error("discharge active while regulator runs");

    // checks: three legible anchor codes of the ramp table
    ramp_anchor_a: assert property (
        @(posedge clk) disable iff (!resetn)
        (cfg_r[3:0] == 4'h2 |=> step_ramp_time_r == 12'h258)
        and (cfg_r[3:0] == 4'hC |=> step_ramp_time_r == 12'hA28)
        and (cfg_r[3:0] == 4'hF |=> step_ramp_time_r == 12'hC80))
        else $error("ramp time decode wrong");
endmodule // boc_top
`default_nettype wire

// File: verif/testbench.sv
// Purpose: self-checking bench for the output configuration register block
// Assumes: inputs driven at falling edge; pins held slow enough for the syncs
// Notes: table rows cover every ramp code; overheat and reset cases follow
`timescale 1ns/1ps
`default_nettype none
`include "boc_defs.svh"
module testbench;
    import boc_pkg::*;

    // one table row: value written and ramp time it should give
    typedef struct {
        logic [7:0]  d;
        logic [11:0] ramp;
    } boc_row_t;

    logic        clk;                        // 40 MHz bench clock
    logic        resetn;                     // async reset, active low
    logic [7:0]  reg_addr;                   // register port
    logic        reg_wr;
    logic [7:0]  reg_wdata;
    logic [7:0]  reg_rdata_r;
    logic        overheat_pin;               // power stage pins
    logic        regulator_enable_pin;
    logic        full_duty_inhibit_r;        // controls out
    logic        forced_pulse_width_mode_r;
    logic        light_load_mode_r;
    boc_sw_mode_t sw_mode_r;
    logic        overheat_latched_r;
    logic        powerdown_discharge_r;
    logic [11:0] step_ramp_time_r;
    int          num_errors = 0;             // mismatch count
    int          checks = 0;                 // comparison count
    boc_row_t    rows [16];                  // ordinary cases

    boc_top u_dut (
        .clk                       (clk),
        .resetn                    (resetn),
        .reg_addr                  (reg_addr),
        .reg_wr                    (reg_wr),
        .reg_wdata                 (reg_wdata),
        .reg_rdata_r               (reg_rdata_r),
        .overheat_pin              (overheat_pin),
        .regulator_enable_pin      (regulator_enable_pin),
        .full_duty_inhibit_r       (full_duty_inhibit_r),
        .forced_pulse_width_mode_r (forced_pulse_width_mode_r),
        .light_load_mode_r         (light_load_mode_r),
        .sw_mode_r                 (sw_mode_r),
        .overheat_latched_r        (overheat_latched_r),
        .powerdown_discharge_r     (powerdown_discharge_r),
        .step_ramp_time_r          (step_ramp_time_r)
    );

    // half period 12.5 ns
    always #12.5 clk = ~clk;

    // compare and count; case inequality so unknowns fail
    task automatic check(input logic [11:0] seen, input logic [11:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // verdict, single exit point
    task automatic end_of_test;
        $display("checks=%0d num_errors=%0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // one write strobe; address returns to the register so reads follow
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_wr = 1'b1;
        reg_wdata = d;
        @(negedge clk);
        reg_wr = 1'b0;
        reg_addr = `BOC_OUTCFG_ADDR;
        @(negedge clk);
    endtask

    // one overheat pulse, 3 cycles high and 5 low, long enough for the syncs
    task automatic heat;
        @(negedge clk);
        overheat_pin = 1'b1;
        repeat (3) @(negedge clk);
        overheat_pin = 1'b0;
        repeat (5) @(negedge clk);
    endtask

    // drive the enable pin and let it settle through the syncs
    task automatic enable(input logic v);
        regulator_enable_pin = v;
        repeat (5) @(negedge clk);
    endtask

    // watchdog: the whole run takes under two hundred cycles
    initial begin
        #50000;
        num_errors++;
        end_of_test;
    end

    initial begin
        clk = 1'b0;
        resetn = 1'b0;
        reg_addr = `BOC_OUTCFG_ADDR;
        reg_wr = 1'b0;
        reg_wdata = 8'h00;
        overheat_pin = 1'b0;
        regulator_enable_pin = 1'b1;
        rows = '{'{8'h80, 12'h0C8}, '{8'h41, 12'h190}, '{8'hA2, 12'h258},
                 '{8'hD3, 12'h320}, '{8'h04, 12'h3E8}, '{8'hE5, 12'h4B0},
                 '{8'h26, 12'h578}, '{8'h37, 12'h640}, '{8'hC8, 12'h708},
                 '{8'h19, 12'h7D0}, '{8'h5A, 12'h898}, '{8'h6B, 12'h960},
                 '{8'hDC, 12'hA28}, '{8'h2D, 12'hAF0}, '{8'hEE, 12'hBB8},
                 '{8'hFF, 12'hC80}};
        repeat (3) @(posedge clk);
        @(negedge clk);
        resetn = 1'b1;
        @(negedge clk);
        // power-on values
        check(reg_rdata_r, 12'h000);
        check(light_load_mode_r, 12'h001);
        check(step_ramp_time_r, 12'h0C8);
        check({full_duty_inhibit_r, forced_pulse_width_mode_r, overheat_latched_r,
               powerdown_discharge_r}, 12'h000);
        // table: every field and every ramp code, enable high so no discharge
        foreach (rows[i]) begin
            wr(`BOC_OUTCFG_ADDR, rows[i].d);
            check(reg_rdata_r, rows[i].d);
            check(full_duty_inhibit_r, rows[i].d[7]);
            check(forced_pulse_width_mode_r, rows[i].d[6]);
            check(light_load_mode_r, !rows[i].d[6]);
            check(sw_mode_r, rows[i].d[6]);
            check(powerdown_discharge_r, 12'h000);
            check(step_ramp_time_r, rows[i].ramp);
        end
        // unmapped write ignored, unmapped read gives zero
        wr(8'h02, 8'h00);
        check(reg_rdata_r, 8'hFF);
        reg_addr = 8'h02;
        @(negedge clk);
        check(reg_rdata_r, 8'h00);
        reg_addr = `BOC_OUTCFG_ADDR;
        // back-to-back writes, last one wins
        reg_wr = 1'b1;
        reg_wdata = 8'hAA;
        @(negedge clk);
        reg_wdata = 8'h55;
        @(negedge clk);
        reg_wr = 1'b0;
        @(negedge clk);
        check(reg_rdata_r, 8'h55);
        // discharge follows the enable pin when bit 4 is set
        wr(`BOC_OUTCFG_ADDR, 8'h10);
        enable(1'b0);
        check(powerdown_discharge_r, 12'h001);
        enable(1'b1);
        check(powerdown_discharge_r, 12'h000);
        // immediate latch policy: first event latches
        heat;
        check(overheat_latched_r, 12'h001);
        check(powerdown_discharge_r, 12'h001);
        enable(1'b0);
        enable(1'b1);
        check(overheat_latched_r, 12'h000);
        // counted policy: events while disabled are refused, then the fourth latches
        wr(`BOC_OUTCFG_ADDR, 8'h30);
        enable(1'b0);
        repeat (2) heat;
        enable(1'b1);
        repeat (3) heat;
        check(overheat_latched_r, 12'h000);
        heat;
        check(overheat_latched_r, 12'h001);
        // reset in mid-run clears register and latch
        resetn = 1'b0;
        repeat (2) @(negedge clk);
        resetn = 1'b1;
        @(negedge clk);
        check(reg_rdata_r, 12'h000);
        check(overheat_latched_r, 12'h000);
        check(step_ramp_time_r, 12'h0C8);
        end_of_test;
    end
endmodule // testbench
`default_nettype wire
